/* File: logic/cwd_pkg.sv */
// shared constants and types for the configuration word decoder
package cwd_pkg;

  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CFG_WIDTH = 14;

  // configuration word location and contents
  localparam logic [13:0] CFG_WORD_ADDR = 14'h2007;
  localparam logic [13:0] CFG_ERASED = 14'h3FFF;
  localparam logic [13:0] CFG_UNIMPL_MASK = 14'h3FA0;
  localparam int unsigned BROWNOUT_RESET_ENABLE_BIT = 6;
  localparam int unsigned CP_BIT = 4;
  localparam int unsigned POWERUP_DELAY_ENABLE_N_BIT = 3;
  localparam int unsigned WATCHDOG_ENABLE_BIT = 2;
  localparam int unsigned OSC_LSB = 0;
  localparam logic [13:0] UNMAPPED_READ = 14'h0000;

  typedef enum logic [1:0] {
    OSC_LP = 2'h0,
    OSC_XT = 2'h1,
    OSC_HS = 2'h2,
    OSC_RC = 2'h3
  } cwd_osc_mode_t;

  // power-up delay: time in ms, cycles derived from the clock rate
  localparam int unsigned POWERUP_DELAY_MS = 72;
  localparam int unsigned POWERUP_DELAY_CYCLES = (CLK_HZ / 1000) * POWERUP_DELAY_MS;
  localparam int unsigned POWERUP_DELAY_TIMER_CNT_W = 22;

  // oscillator start-up: edges of the oscillator input pin
  localparam int unsigned OST_OSC_CYCLES = 1024;
  localparam int unsigned OST_CNT_W = 11;

  // private watchdog oscillator model and watchdog period
  localparam int unsigned RC_TICK_CYCLES = 40;
  localparam int unsigned RC_CNT_W = 6;
  localparam int unsigned WDT_TIMEOUT_TICKS = 16;
  localparam int unsigned WDT_CNT_W = 5;

  localparam logic [2:0] SYNC_RESET = 3'h7;

endpackage

/* File: logic/cwd_ctl_if.sv */
// carrier between the sequencer and its two timing helpers
`timescale 1ns/100ps
interface cwd_ctl_if;
  logic ost_start;
  logic ost_done;
  logic rc_tick;

  modport core (output ost_start, input ost_done, input rc_tick);
  modport oscillator_startup_timer (input ost_start, output ost_done);
  modport rc (output rc_tick);
endinterface

/* File: logic/cwd_rc_osc.sv */
// private watchdog oscillator model, a free running tick source
`timescale 1ns/100ps
module cwd_rc_osc (
  input wire logic clk,
  input wire logic rst,
  cwd_ctl_if.rc ctl
);

  typedef struct packed {
    logic [cwd_pkg::RC_CNT_W-1:0] cnt;
    logic tick;
  } cwd_rc_state_t;

  cwd_rc_state_t st;
  cwd_rc_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt == cwd_pkg::RC_CNT_W'(cwd_pkg::RC_TICK_CYCLES - 1)) begin
      next_st.cnt = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ctl.rc_tick = st.tick;

endmodule

/* File: logic/cwd_osc_startup.sv */
// oscillator start-up counter on edges of the oscillator input pin
`timescale 1ns/100ps
module cwd_osc_startup (
  input wire logic clk,
  input wire logic rst,
  input wire logic oscillator_input_pin,
  cwd_ctl_if.oscillator_startup_timer ctl
);

  typedef struct packed {
    logic [2:0] sync;
    logic level;
    logic [cwd_pkg::OST_CNT_W-1:0] cnt;
    logic done;
  } cwd_ost_state_t;

  cwd_ost_state_t st;
  cwd_ost_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.sync = {st.sync[1:0], oscillator_input_pin};
    if (st.sync[1] == st.sync[2]) begin
      next_st.level = st.sync[2];
    end
    if (!ctl.ost_start) begin
      next_st.cnt = '0;
      next_st.done = 1'b0;
    end else if (!st.done && next_st.level && !st.level) begin
      // RULE_15 RULE_14
      next_st.cnt = st.cnt + 1'b1;
      if (st.cnt == cwd_pkg::OST_CNT_W'(cwd_pkg::OST_OSC_CYCLES - 1)) begin
        next_st.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ctl.ost_done = st.done;

endmodule

/* File: logic/cwd_top.sv */
// configuration word store, decoder and reset/sleep sequencer
`timescale 1ns/100ps

// Operation
// (RULE_01) programmed bit reads zero, erased reads one
// (RULE_02) word at 2007h, programming mode only
// (RULE_03) erased word is all ones
// (RULE_04) unimplemented bits read back as one
// (RULE_05) bit six enables brown-out reset
// (RULE_06) bit four zero protects all memory
// (RULE_07) bit three zero enables power-up delay
// (RULE_08) bit two enables the watchdog
// (RULE_09) bits one:zero select oscillator mode
// (RULE_10) power-up delay holds reset 72 ms
// (RULE_11) start-up timer holds reset until stable
// (RULE_12) watchdog runs from its private oscillator
// (RULE_13) sleep wakes on reset, watchdog, interrupt
// (RULE_14) high-speed mode accepts external input clock
// (RULE_15) 1024 input edges after delay, crystals
// (RULE_16) brown-out enable forces the power-up delay
// (RULE_17) decoded outputs latched while held in reset
module cwd_top #(
  parameter int unsigned POWERUP_DELAY_CYCLES = cwd_pkg::POWERUP_DELAY_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic oscillator_input_pin,
  input wire logic mclr_n,
  input wire logic brownout_detect,
  input wire logic sleep_req,
  input wire logic interrupt_req,
  input wire logic watchdog_clear,
  input wire logic prog_mode,
  input wire logic prog_rd,
  input wire logic prog_wr,
  input wire logic prog_erase,
  input wire logic [13:0] prog_addr,
  input wire logic [13:0] prog_wdata,
  output logic [13:0] prog_rdata,
  output logic prog_rvalid,
  output logic device_reset,
  output logic sleeping,
  output logic brownout_reset_enable,
  output logic code_protect_n,
  output logic powerup_delay_enable_n,
  output logic watchdog_enable,
  output logic [1:0] osc_mode_select,
  output logic low_power_crystal_mode,
  output logic crystal_resonator_mode,
  output logic high_speed_crystal_mode,
  output logic rc_osc_mode,
  output logic program_memory_protected,
  output logic brownout_reset,
  output logic powerup_delay_active,
  output logic oscillator_startup_active,
  output logic watchdog_timeout
);

  typedef enum logic [2:0] {
    ST_POWERUP,
    ST_OST,
    ST_RUN,
    ST_SLEEP,
    ST_EXT_HOLD,
    ST_BOR_HOLD
  } cwd_seq_t;

  typedef struct packed {
    logic [13:0] word;
    logic [1:0] osc_mode;
    logic bor_en;
    logic cp_n;
    logic powerup_delay_timer_en_n;
    logic wdt_en;
    cwd_seq_t seq;
    logic [cwd_pkg::POWERUP_DELAY_TIMER_CNT_W-1:0] powerup_delay_timer_cnt;
    logic [cwd_pkg::WDT_CNT_W-1:0] wdt_cnt;
    logic [2:0] mclr_sync;
    logic mclr_level;
    logic [2:0] bor_sync;
    logic bor_level;
    logic [13:0] rdata;
    logic rvalid;
    logic ost_start;
    logic wdt_timeout;
    logic out_reset;
    logic out_sleeping;
    logic out_bor_hold;
    logic out_powerup_delay_timer_active;
    logic out_protected;
    logic [3:0] out_osc_hot;
  } cwd_state_t;

  cwd_state_t st;
  cwd_state_t next_st;
  cwd_ctl_if ctl ();

  // three-stage pin filter: a change counts once stages two and three agree
  function automatic logic filt_update(input logic [2:0] sync, input logic level);
    filt_update = (sync[1] == sync[2]) ? sync[2] : level;
  endfunction

  function automatic logic is_crystal(input logic [1:0] mode);
    is_crystal = (mode != cwd_pkg::OSC_RC);
  endfunction

  // reset is held in every state but run and sleep
  function automatic logic seq_holds(input cwd_seq_t seq);
    seq_holds = (seq != ST_RUN) && (seq != ST_SLEEP);
  endfunction

  // one-hot oscillator decode, bit index equals the select code
  function automatic logic [3:0] osc_hot(input logic [1:0] mode);
    osc_hot = 4'h1 << mode;
  endfunction

  // readback forces unimplemented positions high
  function automatic logic [13:0] read_word(input logic [13:0] word);
    read_word = word | cwd_pkg::CFG_UNIMPL_MASK;
  endfunction

  cwd_rc_osc u_rc (
    .clk(clk),
    .rst(rst),
    .ctl(ctl.rc)
  );

  cwd_osc_startup u_ost (
    .clk(clk),
    .rst(rst),
    .oscillator_input_pin(oscillator_input_pin),
    .ctl(ctl.oscillator_startup_timer)
  );

  assign ctl.ost_start = st.ost_start;

  logic held;
  logic powerup_delay_timer_needed;
  logic wdt_running;
  logic wdt_fire;
  logic ext_reset;
  logic bor_event;

  always_comb begin
    held = seq_holds(st.seq);
    powerup_delay_timer_needed = !st.powerup_delay_timer_en_n || st.bor_en; // RULE_07 RULE_16
    wdt_running = st.wdt_en && !held; // RULE_08
    wdt_fire = wdt_running && ctl.rc_tick && // RULE_12
      (st.wdt_cnt == cwd_pkg::WDT_CNT_W'(cwd_pkg::WDT_TIMEOUT_TICKS - 1));
    ext_reset = !st.mclr_level || prog_mode;
    bor_event = st.bor_en && st.bor_level; // RULE_05
  end

  always_comb begin
    next_st = st;
    next_st.rvalid = 1'b0;
    next_st.wdt_timeout = 1'b0;
    next_st.mclr_sync = {st.mclr_sync[1:0], mclr_n};
    next_st.mclr_level = filt_update(st.mclr_sync, st.mclr_level);
    next_st.bor_sync = {st.bor_sync[1:0], brownout_detect};
    next_st.bor_level = filt_update(st.bor_sync, st.bor_level);

    // config store reachable only in programming mode
    if (prog_mode) begin // RULE_02
      if (prog_erase) begin
        next_st.word = cwd_pkg::CFG_ERASED; // RULE_03
      end else if (prog_wr && prog_addr == cwd_pkg::CFG_WORD_ADDR) begin
        next_st.word = st.word & (prog_wdata | cwd_pkg::CFG_UNIMPL_MASK); // RULE_01
      end
      if (prog_rd) begin
        next_st.rvalid = 1'b1;
        if (prog_addr == cwd_pkg::CFG_WORD_ADDR) begin
          next_st.rdata = read_word(st.word); // RULE_04
        end else begin
          next_st.rdata = cwd_pkg::UNMAPPED_READ;
        end
      end
    end

    // decoded fields follow the stored word only while held in reset
    if (held) begin // RULE_17
      next_st.bor_en = st.word[cwd_pkg::BROWNOUT_RESET_ENABLE_BIT]; // RULE_05
      next_st.cp_n = st.word[cwd_pkg::CP_BIT]; // RULE_06
      next_st.powerup_delay_timer_en_n = st.word[cwd_pkg::POWERUP_DELAY_ENABLE_N_BIT]; // RULE_07
      next_st.wdt_en = st.word[cwd_pkg::WATCHDOG_ENABLE_BIT]; // RULE_08
      next_st.osc_mode = st.word[cwd_pkg::OSC_LSB +: 2]; // RULE_09
    end

    // watchdog counts private oscillator ticks
    if (!wdt_running || watchdog_clear || wdt_fire) begin
      next_st.wdt_cnt = '0;
    end else if (ctl.rc_tick) begin // RULE_12
      next_st.wdt_cnt = st.wdt_cnt + 1'b1;
    end
    next_st.wdt_timeout = wdt_fire && !watchdog_clear;

    next_st.ost_start = 1'b0;
    if (bor_event) begin
      next_st.seq = ST_BOR_HOLD;
      next_st.powerup_delay_timer_cnt = '0;
    end else if (ext_reset) begin
      next_st.seq = ST_EXT_HOLD;
      next_st.powerup_delay_timer_cnt = '0;
    end else begin
      unique case (st.seq)
        ST_POWERUP: begin
          if (!powerup_delay_timer_needed ||
              st.powerup_delay_timer_cnt == cwd_pkg::POWERUP_DELAY_TIMER_CNT_W'(POWERUP_DELAY_CYCLES - 1)) begin // RULE_10
            next_st.powerup_delay_timer_cnt = '0;
            if (is_crystal(st.osc_mode)) begin // RULE_15
              next_st.seq = ST_OST;
              next_st.ost_start = 1'b1;
            end else begin
              next_st.seq = ST_RUN;
            end
          end else begin
            next_st.powerup_delay_timer_cnt = st.powerup_delay_timer_cnt + 1'b1; // RULE_10
          end
        end
        ST_OST: begin
          if (ctl.ost_done && st.ost_start) begin // RULE_11
            next_st.seq = ST_RUN;
          end else begin
            next_st.ost_start = 1'b1;
          end
        end
        ST_RUN: begin
          if (wdt_fire && !watchdog_clear) begin
            next_st.seq = ST_EXT_HOLD;
          end else if (sleep_req) begin
            next_st.seq = ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if ((wdt_fire && !watchdog_clear) || interrupt_req) begin // RULE_13
            if (is_crystal(st.osc_mode)) begin // RULE_15
              next_st.seq = ST_OST;
              next_st.ost_start = 1'b1;
            end else begin
              next_st.seq = ST_RUN;
            end
          end
        end
        ST_EXT_HOLD: begin
          next_st.seq = ST_RUN; // RULE_13
        end
        ST_BOR_HOLD: begin
          next_st.seq = ST_POWERUP; // RULE_16
        end
      endcase
    end

    // outputs are registered copies of the next state decode
    next_st.out_reset = seq_holds(next_st.seq);
    next_st.out_sleeping = (next_st.seq == ST_SLEEP);
    next_st.out_bor_hold = (next_st.seq == ST_BOR_HOLD);
    next_st.out_powerup_delay_timer_active = (next_st.seq == ST_POWERUP);
    next_st.out_protected = !next_st.cp_n; // RULE_06
    next_st.out_osc_hot = osc_hot(next_st.osc_mode); // RULE_09
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
      st.word <= cwd_pkg::CFG_ERASED; // RULE_03
      st.osc_mode <= cwd_pkg::OSC_RC;
      st.bor_en <= 1'b1;
      st.cp_n <= 1'b1;
      st.powerup_delay_timer_en_n <= 1'b1;
      st.wdt_en <= 1'b1;
      st.seq <= ST_POWERUP;
      st.mclr_sync <= cwd_pkg::SYNC_RESET;
      st.mclr_level <= 1'b1;
      // outputs start as the erased, held decode
      st.out_reset <= 1'b1;
      st.out_powerup_delay_timer_active <= 1'b1;
      st.out_osc_hot <= 4'h8;
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    prog_rdata = st.rdata;
    prog_rvalid = st.rvalid;
    device_reset = st.out_reset;
    sleeping = st.out_sleeping;
    brownout_reset_enable = st.bor_en;
    code_protect_n = st.cp_n;
    powerup_delay_enable_n = st.powerup_delay_timer_en_n;
    watchdog_enable = st.wdt_en;
    osc_mode_select = st.osc_mode;
    low_power_crystal_mode = st.out_osc_hot[cwd_pkg::OSC_LP];
    crystal_resonator_mode = st.out_osc_hot[cwd_pkg::OSC_XT];
    high_speed_crystal_mode = st.out_osc_hot[cwd_pkg::OSC_HS]; // RULE_14
    rc_osc_mode = st.out_osc_hot[cwd_pkg::OSC_RC];
    program_memory_protected = st.out_protected; // RULE_06
    brownout_reset = st.out_bor_hold;
    powerup_delay_active = st.out_powerup_delay_timer_active;
    oscillator_startup_active = st.ost_start;
    watchdog_timeout = st.wdt_timeout;
  end

endmodule

/* File: test/cwd_monitor.sv */
// assertion checker on the decoder top ports
`timescale 1ns/100ps
module cwd_monitor #(
  parameter int unsigned POWERUP_DELAY_CYCLES = 20
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic prog_mode,
  input wire logic prog_rd,
  input wire logic [13:0] prog_addr,
  input wire logic [13:0] prog_rdata,
  input wire logic prog_rvalid,
  input wire logic device_reset,
  input wire logic sleeping,
  input wire logic brownout_reset_enable,
  input wire logic code_protect_n,
  input wire logic powerup_delay_enable_n,
  input wire logic watchdog_enable,
  input wire logic [1:0] osc_mode_select,
  input wire logic low_power_crystal_mode,
  input wire logic crystal_resonator_mode,
  input wire logic high_speed_crystal_mode,
  input wire logic rc_osc_mode,
  input wire logic program_memory_protected,
  input wire logic brownout_reset,
  input wire logic powerup_delay_active,
  input wire logic watchdog_timeout
);
  logic [21:0] powerup_delay_timer_cnt;
  logic [21:0] next_powerup_delay_timer_cnt;
  always_comb next_powerup_delay_timer_cnt = powerup_delay_active ? powerup_delay_timer_cnt + 22'h000001 : 22'h000000;
  always_ff @(posedge clk) powerup_delay_timer_cnt <= rst ? 22'h000000 : next_powerup_delay_timer_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_read_answer: assert property (prog_rvalid == ($past(prog_rd) && $past(prog_mode)))
    else $error("read answer wrong");
  a_unimpl_ones: assert property (prog_rvalid && $past(prog_addr) == 14'h2007
    |-> (prog_rdata & 14'h3FA0) == 14'h3FA0) else $error("unused bits not one");
  a_protect_decode: assert property (program_memory_protected == !code_protect_n)
    else $error("protect decode wrong");
  a_osc_onehot: assert property ({rc_osc_mode, high_speed_crystal_mode,
    crystal_resonator_mode, low_power_crystal_mode} == 4'h1 << osc_mode_select)
    else $error("osc decode");
  a_cfg_frozen: assert property (!device_reset && !$past(device_reset) |-> $stable({
    brownout_reset_enable, code_protect_n, powerup_delay_enable_n, watchdog_enable,
    osc_mode_select})) else $error("config moved in run");
  a_wdt_gated: assert property (watchdog_timeout |-> watchdog_enable)
    else $error("watchdog while off");
  a_powerup_delay_timer_bound: assert property (powerup_delay_active
    |-> powerup_delay_timer_cnt < POWERUP_DELAY_CYCLES) else $error("power-up delay too long");
  a_bor_powerup_delay_timer: assert property ($fell(brownout_reset) |-> powerup_delay_active)
    else $error("no delay after brown-out");
  c_sleep_exit: cover property ($fell(sleeping));
  c_wdt: cover property (watchdog_timeout);
  c_bor: cover property ($rose(brownout_reset));
endmodule
bind cwd_top cwd_monitor #(.POWERUP_DELAY_CYCLES(POWERUP_DELAY_CYCLES)) u_mon (.clk, .rst,
  .prog_mode, .prog_rd, .prog_addr, .prog_rdata, .prog_rvalid, .device_reset, .sleeping,
  .brownout_reset_enable, .code_protect_n, .powerup_delay_enable_n, .watchdog_enable,
  .osc_mode_select, .low_power_crystal_mode, .crystal_resonator_mode, .high_speed_crystal_mode,
  .rc_osc_mode, .program_memory_protected, .brownout_reset, .powerup_delay_active,
  .watchdog_timeout);

/* File: test/cwd_programmer.sv */
// programmer model: programming port access and external clock
`timescale 1ns/100ps
module cwd_programmer (
  input wire logic clk,
  input wire logic osc_run,
  output logic prog_mode,
  output logic prog_rd,
  output logic prog_wr,
  output logic prog_erase,
  output logic [13:0] prog_addr,
  output logic [13:0] prog_wdata,
  input wire logic [13:0] prog_rdata,
  input wire logic prog_rvalid,
  output logic oscillator_input_pin
);
  initial begin
    {prog_mode, prog_rd, prog_wr, prog_erase, oscillator_input_pin} = 5'h00;
    prog_addr = 14'h0000;
    prog_wdata = 14'h0000;
  end
  logic div = 1'b0;
  // external clock at a quarter of the system rate, slow enough for the pin filter
  always @(negedge clk) begin
    if (osc_run) begin
      div <= !div;
      if (div) oscillator_input_pin <= !oscillator_input_pin;
    end
  end
  task automatic set_mode(input logic m);
    @(negedge clk);
    prog_mode = m;
  endtask
  // op 0 read, 1 write, 2 erase; one strobe cycle
  task automatic access(input int op, input logic [13:0] a, input logic [13:0] d,
    output logic [13:0] q);
    @(negedge clk);
    prog_addr = a;
    prog_wdata = d;
    prog_rd = (op == 0);
    prog_wr = (op == 1);
    prog_erase = (op == 2);
    @(negedge clk);
    {prog_rd, prog_wr, prog_erase} = 3'h0;
    prog_addr = ~a;
    prog_wdata = ~d;
    q = prog_rvalid ? prog_rdata : 14'hXXXX;
  endtask
endmodule

/* File: test/config_word_decoder_test.sv */
// self-checking bench for the configuration word decoder
`timescale 1ns/100ps
module config_word_decoder_test;
  localparam int unsigned POWERUP_DELAY_TIMER = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic mclr_n = 1'b1;
  logic bod = 1'b0;
  logic sleep_req = 1'b0;
  logic irq = 1'b0;
  logic wdt_clr = 1'b0;
  logic osc_run = 1'b0;
  logic pin, pm, prd, pwr, per, rvalid, dev_rst, sleeping;
  logic [13:0] paddr, pwdata, prdata, rd;
  logic bor_en, cp_n, powerup_delay_timer_n, wdt_en, lp, xt, hs, rc, prot, bor, powerup_delay_timer_act, ost_act, wdt_to;
  logic [1:0] osc_sel;
  int error_cnt = 0;
  int checks_done = 0;
  int n;
  cwd_programmer u_prog (.clk, .osc_run, .prog_mode(pm), .prog_rd(prd), .prog_wr(pwr),
    .prog_erase(per), .prog_addr(paddr), .prog_wdata(pwdata), .prog_rdata(prdata),
    .prog_rvalid(rvalid), .oscillator_input_pin(pin));
  cwd_top #(.POWERUP_DELAY_CYCLES(POWERUP_DELAY_TIMER)) u_dut (.clk, .rst, .oscillator_input_pin(pin), .mclr_n,
    .brownout_detect(bod), .sleep_req, .interrupt_req(irq), .watchdog_clear(wdt_clr),
    .prog_mode(pm), .prog_rd(prd), .prog_wr(pwr), .prog_erase(per), .prog_addr(paddr),
    .prog_wdata(pwdata), .prog_rdata(prdata), .prog_rvalid(rvalid), .device_reset(dev_rst),
    .sleeping, .brownout_reset_enable(bor_en), .code_protect_n(cp_n),
    .powerup_delay_enable_n(powerup_delay_timer_n), .watchdog_enable(wdt_en), .osc_mode_select(osc_sel),
    .low_power_crystal_mode(lp), .crystal_resonator_mode(xt), .high_speed_crystal_mode(hs),
    .rc_osc_mode(rc), .program_memory_protected(prot), .brownout_reset(bor),
    .powerup_delay_active(powerup_delay_timer_act), .oscillator_startup_active(ost_act),
    .watchdog_timeout(wdt_to));
  initial forever #12.5 clk = ~clk;
  task automatic check(input logic [13:0] seen, input logic [13:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wait_for(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic pulse_sleep();
    sleep_req = 1'b1;
    @(negedge clk);
    sleep_req = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  function automatic logic [5:0] cfg();
    return {bor_en, cp_n, powerup_delay_timer_n, wdt_en, osc_sel};
  endfunction
  task automatic t_power_up();
    wait_for(dev_rst, 1'b0, POWERUP_DELAY_TIMER + 20);
    check(n >= POWERUP_DELAY_TIMER && n <= POWERUP_DELAY_TIMER + 8, 1'b1);
    check(cfg(), 6'h3F);
    check({rc, prot, bor_en}, 3'h5);
    wait_for(wdt_to, 1'b1, 1000);
    check(n >= 560 && n <= 680, 1'b1);
    repeat (4) @(negedge clk);
    pulse_sleep();
    check(sleeping, 1'b1);
    wait_for(wdt_to, 1'b1, 1000);
    repeat (3) @(negedge clk);
    check({sleeping, dev_rst}, 2'h0);
    $display("power-up test done");
  endtask
  task automatic t_program();
    u_prog.access(0, 14'h2007, 14'h0000, rd);
    check(rvalid, 1'b0);
    u_prog.set_mode(1'b1);
    u_prog.access(0, 14'h2007, 14'h0000, rd);
    check(rd, 14'h3FFF);
    u_prog.access(0, 14'h0007, 14'h0000, rd);
    check(rd, 14'h0000);
    u_prog.access(1, 14'h2007, 14'h0002, rd);
    u_prog.access(0, 14'h2007, 14'h0000, rd);
    check(rd, 14'h3FA2);
    u_prog.set_mode(1'b0);
    wait_for(dev_rst, 1'b0, 10);
    check(cfg(), 6'h02);
    check({hs, prot, bor_en, wdt_en}, 4'hC);
    $display("program test done");
  endtask
  task automatic t_hs_wake();
    pulse_sleep();
    repeat (700) @(negedge clk);
    check(sleeping, 1'b1);
    osc_run = 1'b1;
    irq = 1'b1;
    @(negedge clk);
    irq = 1'b0;
    check(ost_act, 1'b1);
    wait_for(dev_rst, 1'b0, 4200);
    check(n >= 4090 && n <= 4106, 1'b1);
    check(sleeping, 1'b0);
    osc_run = 1'b0;
    $display("wake test done");
  endtask
  task automatic t_brownout();
    u_prog.set_mode(1'b1);
    u_prog.access(2, 14'h2007, 14'h0000, rd);
    u_prog.access(0, 14'h2007, 14'h0000, rd);
    check(rd, 14'h3FFF);
    u_prog.set_mode(1'b0);
    wait_for(dev_rst, 1'b0, 10);
    bod = 1'b1;
    repeat (6) @(negedge clk);
    check({bor, dev_rst}, 2'h3);
    bod = 1'b0;
    wait_for(bor, 1'b0, 10);
    check(powerup_delay_timer_act, 1'b1);
    wait_for(powerup_delay_timer_act, 1'b0, POWERUP_DELAY_TIMER + 5);
    check(n >= POWERUP_DELAY_TIMER - 2 && n <= POWERUP_DELAY_TIMER, 1'b1);
    $display("brown-out test done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    t_power_up();
    t_program();
    t_hs_wake();
    t_brownout();
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end
endmodule
